// ---- pkg/rfs_pkg.sv ----
// register map, field positions and reset values of the fault status and mask block
package rfs_pkg;
    localparam logic [7:0] ADDR_OVERCURRENT_LIVE  = 8'h19;
    localparam logic [7:0] ADDR_THERMAL_SUPPLY    = 8'h1A;
    localparam logic [7:0] ADDR_CHIP_SUSPEND      = 8'h1B;
    localparam logic [7:0] ADDR_UNDERVOLT_MASK    = 8'h1C;
    localparam logic [7:0] ADDR_OVERCURRENT_MASK  = 8'h1D;
    localparam logic [7:0] ADDR_THERMAL_MASK      = 8'h1E;
    localparam logic [7:0] ADDR_UNDERVOLT_FLAGS   = 8'h15;
    localparam logic [7:0] ADDR_OVERCURRENT_FLAGS = 8'h16;
    localparam logic [7:0] ADDR_THERMAL_FLAGS     = 8'h17;
    localparam logic [7:0] ADDR_UNDERVOLT_LIVE    = 8'h18;
    localparam int         NUM_REGS               = 7;
    localparam int         NUM_INPUTS             = 5;
    localparam int         BIT_THERMAL_SHUTDOWN   = 7;
    localparam int         BIT_THERMAL_WARNING    = 6;
    localparam int         BIT_SYSTEM_SUPPLY      = 5;
    localparam int         BIT_CHIP_SUSPENDED     = 6;
    localparam logic [7:0] REG_RESET              = 8'h00;
    localparam logic [7:0] USED_SEVEN             = 8'h7F;
    localparam logic [7:0] USED_EIGHT             = 8'hFF;
    localparam logic [7:0] USED_SUSPEND           = 8'h40;
endpackage : rfs_pkg

// ---- rtl/rfs_event_latch.sv ----
// sticky event flags for one eight-bit group with read-and-clear
`timescale 1ns/1ps
`default_nettype none
module rfs_event_latch (
    // clock and reset
    input  wire logic       i_clock,
    input  wire logic       i_reset,
    // events and clear
    input  wire logic [7:0] i_event,
    input  wire logic [7:0] i_used,
    input  wire logic       i_read_clear,
    // flags
    output logic      [7:0] o_flag
);
    logic [7:0] next_flag;

    // a new event in the clearing cycle survives the clear
    assign next_flag = ((i_read_clear ? 8'h00 : o_flag) | i_event) & i_used;

    always_ff @(posedge i_clock) begin
        if (i_reset) begin
            o_flag <= rfs_pkg::REG_RESET;
        end else begin
            o_flag <= next_flag;
        end
    end
endmodule : rfs_event_latch
`default_nettype wire

// ---- rtl/rfs_fault_status.sv ----
// live fault status, latched fault flags, masks and interrupt pin of the regulator manager
`timescale 1ns/1ps
`default_nettype none
// Notes on behaviour
// - Over-current status bits 6..0 follow over-current on regulators 7..1 live.
// - Thermal status bit 7 reads 1 while the device sits in thermal shutdown.
// - Thermal status bit 6 reads 1 while temperature is above the warning level.
// - Thermal status bit 5 reads 1 while the system supply is under its lockout threshold.
// - Bits 4..0 show input lockout for inputs 7, 6, 5, shared 3/4, shared 1/2 only while fed regulators are enabled.
// - Chip state bit 6 reads 1 while the whole chip is suspended by a global fault.
// - First mask bits 6..0 keep undervoltage events of regulators 7..1 off the interrupt pin.
// - Second mask bits 6..0 keep over-current events of regulators 7..1 off the interrupt pin.
// - Third mask bit 7 gates thermal shutdown and bit 6 gates thermal warning events.
// - Third mask bit 5 gates system supply lockout and bits 4..0 gate the input lockout events.
// - A mask bit of 0 lets its event drive the interrupt pin.
// - Latched flags set on each fault event and clear when their register is read.
// - A lockout flag is raised both on entering and on leaving lockout.
module rfs_fault_status (
    // clock and reset
    input  wire logic                  i_clock,
    input  wire logic                  i_reset,
    // register port from the serial control bus
    input  wire logic            [7:0] i_reg_addr,
    input  wire logic            [7:0] i_reg_wdata,
    input  wire logic                  i_reg_write,
    input  wire logic                  i_reg_read,
    output logic                 [7:0] o_reg_rdata,
    // fault detector levels from the analog side
    input  wire logic            [6:0] i_reg_undervolt,
    input  wire logic            [6:0] i_reg_overcurrent,
    input  wire logic                  i_thermal_shutdown,
    input  wire logic                  i_thermal_warning,
    input  wire logic                  i_system_supply_low,
    input  wire logic            [4:0] i_input_low,
    input  wire logic            [4:0] i_input_enabled,
    input  wire logic                  i_chip_suspended,
    // interrupt pin, active high
    output logic                       o_interrupt
);
    // two-flop synchronisers for all detector levels
    // field offsets inside the synchroniser word, lowest field first
    localparam int OFS_SUSPEND  = 0;
    localparam int OFS_IN_EN    = OFS_SUSPEND + 1;
    localparam int OFS_IN_LOW   = OFS_IN_EN + rfs_pkg::NUM_INPUTS;
    localparam int OFS_SYS_LOW  = OFS_IN_LOW + rfs_pkg::NUM_INPUTS;
    localparam int OFS_WARNING  = OFS_SYS_LOW + 1;
    localparam int OFS_SHUTDOWN = OFS_WARNING + 1;
    localparam int OFS_OVERCUR  = OFS_SHUTDOWN + 1;
    localparam int OFS_UNDERV   = OFS_OVERCUR + rfs_pkg::NUM_REGS;
    localparam int NSYNC        = OFS_UNDERV + rfs_pkg::NUM_REGS;
    logic [NSYNC-1:0] raw_in;
    logic [NSYNC-1:0] sync_a;
    logic [NSYNC-1:0] sync_b;
    assign raw_in = {i_reg_undervolt, i_reg_overcurrent, i_thermal_shutdown,
                     i_thermal_warning, i_system_supply_low, i_input_low,
                     i_input_enabled, i_chip_suspended};

    always_ff @(posedge i_clock) begin
        if (i_reset) begin
            sync_a <= '0;
            sync_b <= '0;
        end else begin
            sync_a <= raw_in;
            sync_b <= sync_a;
        end
    end

    wire logic [6:0] uv_s;
    wire logic [6:0] oc_s;
    wire logic       tsd_s;
    wire logic       twn_s;
    wire logic       sys_s;
    wire logic [4:0] inlow_s;
    wire logic [4:0] inen_s;
    wire logic       susp_s;
    assign susp_s  = sync_b[OFS_SUSPEND];
    assign inen_s  = sync_b[OFS_IN_EN +: rfs_pkg::NUM_INPUTS];
    assign inlow_s = sync_b[OFS_IN_LOW +: rfs_pkg::NUM_INPUTS];
    assign sys_s   = sync_b[OFS_SYS_LOW];
    assign twn_s   = sync_b[OFS_WARNING];
    assign tsd_s   = sync_b[OFS_SHUTDOWN];
    assign oc_s    = sync_b[OFS_OVERCUR +: rfs_pkg::NUM_REGS];
    assign uv_s    = sync_b[OFS_UNDERV +: rfs_pkg::NUM_REGS];

    // live status registers
    logic [7:0] overcurrent_live_state;
    logic [7:0] thermal_supply_live_state;
    logic [7:0] chip_suspend_state;
    logic [7:0] undervolt_live_state;
    logic [4:0] input_lockout_live;
    logic [7:0] next_thermal_supply;
    logic [7:0] next_overcurrent;
    logic [7:0] next_chip_suspend;
    logic [7:0] next_undervolt;

    // a dropped input on a disabled regulator is not a fault
    assign input_lockout_live = inlow_s & inen_s;
    assign next_overcurrent   = {1'b0, oc_s};
    assign next_undervolt     = {1'b0, uv_s};

    // fields placed by name; every other position stays at its reset zero
    always_comb begin
        next_thermal_supply = rfs_pkg::REG_RESET;
        next_thermal_supply[rfs_pkg::BIT_THERMAL_SHUTDOWN] = tsd_s;
        next_thermal_supply[rfs_pkg::BIT_THERMAL_WARNING] = twn_s;
        next_thermal_supply[rfs_pkg::BIT_SYSTEM_SUPPLY] = sys_s;
        next_thermal_supply[rfs_pkg::NUM_INPUTS-1:0] = input_lockout_live;
    end

    always_comb begin
        next_chip_suspend = rfs_pkg::REG_RESET;
        next_chip_suspend[rfs_pkg::BIT_CHIP_SUSPENDED] = susp_s;
    end

    always_ff @(posedge i_clock) begin
        if (i_reset) begin
            overcurrent_live_state    <= rfs_pkg::REG_RESET;
            thermal_supply_live_state <= rfs_pkg::REG_RESET;
            chip_suspend_state        <= rfs_pkg::REG_RESET;
            undervolt_live_state      <= rfs_pkg::REG_RESET;
        end else begin
            overcurrent_live_state    <= next_overcurrent;
            thermal_supply_live_state <= next_thermal_supply;
            chip_suspend_state        <= next_chip_suspend;
            undervolt_live_state      <= next_undervolt;
        end
    end

    // event detection: rising edges of undervoltage and over-current, both edges of thermal and lockout levels
    logic [7:0] prev_uv;
    logic [7:0] prev_oc;
    logic [7:0] prev_th;
    always_ff @(posedge i_clock) begin
        if (i_reset) begin
            prev_uv <= rfs_pkg::REG_RESET;
        end else begin
            prev_uv <= undervolt_live_state;
        end
    end

    always_ff @(posedge i_clock) begin
        if (i_reset) begin
            prev_oc <= rfs_pkg::REG_RESET;
        end else begin
            prev_oc <= overcurrent_live_state;
        end
    end

    always_ff @(posedge i_clock) begin
        if (i_reset) begin
            prev_th <= rfs_pkg::REG_RESET;
        end else begin
            prev_th <= thermal_supply_live_state;
        end
    end

    wire logic [7:0] uv_event;
    wire logic [7:0] oc_event;
    wire logic [7:0] th_event;
    assign uv_event = undervolt_live_state & ~prev_uv;
    assign oc_event = overcurrent_live_state & ~prev_oc;
    // thermal flags also fire on cooling below hysteresis, lockout on recovery
    assign th_event = thermal_supply_live_state ^ prev_th;

    // register decode
    wire logic sel_uv_mask;
    wire logic sel_oc_mask;
    wire logic sel_th_mask;
    wire logic sel_uv_flag;
    wire logic sel_oc_flag;
    wire logic sel_th_flag;
    assign sel_uv_mask = i_reg_addr == rfs_pkg::ADDR_UNDERVOLT_MASK;
    assign sel_oc_mask = i_reg_addr == rfs_pkg::ADDR_OVERCURRENT_MASK;
    assign sel_th_mask = i_reg_addr == rfs_pkg::ADDR_THERMAL_MASK;
    assign sel_uv_flag = i_reg_addr == rfs_pkg::ADDR_UNDERVOLT_FLAGS;
    assign sel_oc_flag = i_reg_addr == rfs_pkg::ADDR_OVERCURRENT_FLAGS;
    assign sel_th_flag = i_reg_addr == rfs_pkg::ADDR_THERMAL_FLAGS;
    wire logic wr_uv_mask;
    wire logic wr_oc_mask;
    wire logic wr_th_mask;
    wire logic clr_uv_flag;
    wire logic clr_oc_flag;
    wire logic clr_th_flag;
    assign wr_uv_mask  = i_reg_write & sel_uv_mask;
    assign wr_oc_mask  = i_reg_write & sel_oc_mask;
    assign wr_th_mask  = i_reg_write & sel_th_mask;
    // reading a flag group clears it; a new event in that cycle still lands
    assign clr_uv_flag = i_reg_read & sel_uv_flag;
    assign clr_oc_flag = i_reg_read & sel_oc_flag;
    assign clr_th_flag = i_reg_read & sel_th_flag;

    // mask registers; status addresses simply ignore writes
    logic [7:0] undervolt_event_mask;
    logic [7:0] overcurrent_event_mask;
    logic [7:0] thermal_lockout_event_mask;
    // unused mask positions are dropped on write so they read back zero
    wire logic [7:0] uv_mask_wdata;
    wire logic [7:0] oc_mask_wdata;
    wire logic [7:0] th_mask_wdata;
    assign uv_mask_wdata = i_reg_wdata & rfs_pkg::USED_SEVEN;
    assign oc_mask_wdata = i_reg_wdata & rfs_pkg::USED_SEVEN;
    assign th_mask_wdata = i_reg_wdata & rfs_pkg::USED_EIGHT;

    always_ff @(posedge i_clock) begin
        if (i_reset) begin
            undervolt_event_mask <= rfs_pkg::REG_RESET;
        end else if (wr_uv_mask) begin
            undervolt_event_mask <= uv_mask_wdata;
        end
    end

    always_ff @(posedge i_clock) begin
        if (i_reset) begin
            overcurrent_event_mask <= rfs_pkg::REG_RESET;
        end else if (wr_oc_mask) begin
            overcurrent_event_mask <= oc_mask_wdata;
        end
    end

    always_ff @(posedge i_clock) begin
        if (i_reset) begin
            thermal_lockout_event_mask <= rfs_pkg::REG_RESET;
        end else if (wr_th_mask) begin
            thermal_lockout_event_mask <= th_mask_wdata;
        end
    end

    // latched flags, cleared by reading their register
    wire logic [7:0] uv_flag;
    wire logic [7:0] oc_flag;
    wire logic [7:0] th_flag;
    rfs_event_latch u_uv_latch (
        .i_clock      (i_clock),
        .i_reset      (i_reset),
        .i_event      (uv_event),
        .i_used       (rfs_pkg::USED_SEVEN),
        .i_read_clear (clr_uv_flag),
        .o_flag       (uv_flag)
    );
    rfs_event_latch u_oc_latch (
        .i_clock      (i_clock),
        .i_reset      (i_reset),
        .i_event      (oc_event),
        .i_used       (rfs_pkg::USED_SEVEN),
        .i_read_clear (clr_oc_flag),
        .o_flag       (oc_flag)
    );
    rfs_event_latch u_th_latch (
        .i_clock      (i_clock),
        .i_reset      (i_reset),
        .i_event      (th_event),
        .i_used       (rfs_pkg::USED_EIGHT),
        .i_read_clear (clr_th_flag),
        .o_flag       (th_flag)
    );

    // interrupt: a set mask bit hides its flag, a clear one passes it
    wire logic [7:0] uv_pass;
    wire logic [7:0] oc_pass;
    wire logic [7:0] th_pass;
    assign uv_pass = uv_flag & ~undervolt_event_mask;
    assign oc_pass = oc_flag & ~overcurrent_event_mask;
    assign th_pass = th_flag & ~thermal_lockout_event_mask;
    // registered so the pin never glitches while flags and masks settle
    wire logic irq_pending;
    assign irq_pending = |{uv_pass, oc_pass, th_pass};

    always_ff @(posedge i_clock) begin
        if (i_reset) begin
            o_interrupt <= 1'b0;
        end else begin
            o_interrupt <= irq_pending;
        end
    end

    // read data, registered; unmapped addresses read zero
    logic [7:0] next_rdata;
    always_comb begin
        case (i_reg_addr)
            rfs_pkg::ADDR_UNDERVOLT_FLAGS:   next_rdata = uv_flag;
            rfs_pkg::ADDR_OVERCURRENT_FLAGS: next_rdata = oc_flag;
            rfs_pkg::ADDR_THERMAL_FLAGS:     next_rdata = th_flag;
            rfs_pkg::ADDR_UNDERVOLT_LIVE:    next_rdata = undervolt_live_state;
            rfs_pkg::ADDR_OVERCURRENT_LIVE:  next_rdata = overcurrent_live_state;
            rfs_pkg::ADDR_THERMAL_SUPPLY:    next_rdata = thermal_supply_live_state;
            rfs_pkg::ADDR_CHIP_SUSPEND:      next_rdata = chip_suspend_state & rfs_pkg::USED_SUSPEND;
            rfs_pkg::ADDR_UNDERVOLT_MASK:    next_rdata = undervolt_event_mask;
            rfs_pkg::ADDR_OVERCURRENT_MASK:  next_rdata = overcurrent_event_mask;
            rfs_pkg::ADDR_THERMAL_MASK:      next_rdata = thermal_lockout_event_mask;
            default:                         next_rdata = rfs_pkg::REG_RESET;
        endcase
    end

    always_ff @(posedge i_clock) begin
        if (i_reset) begin
            o_reg_rdata <= rfs_pkg::REG_RESET;
        end else if (i_reg_read) begin
            o_reg_rdata <= next_rdata;
        end
    end
endmodule : rfs_fault_status
`default_nettype wire

// ---- verif/rfs_fault_status_asserts.sv ----
// port-level checker for the fault status block
`timescale 1ns/1ps
`default_nettype none
module rfs_fault_status_asserts (
    input wire logic       i_clock,
    input wire logic       i_reset,
    input wire logic [7:0] i_reg_addr,
    input wire logic [7:0] i_reg_wdata,
    input wire logic       i_reg_write,
    input wire logic       i_reg_read,
    input wire logic [7:0] o_reg_rdata,
    input wire logic [6:0] i_reg_undervolt,
    input wire logic [6:0] i_reg_overcurrent,
    input wire logic       i_thermal_shutdown,
    input wire logic       i_thermal_warning,
    input wire logic       i_system_supply_low,
    input wire logic [4:0] i_input_low,
    input wire logic [4:0] i_input_enabled,
    input wire logic       i_chip_suspended,
    input wire logic       o_interrupt
);
    logic [27:0] det, det_q;
    logic [2:0]  quiet, act;
    logic [7:0]  th;
    logic        q, rd19, rd1a, rd1b, wr_m, wr_t, rd_x;
    // live values only compared once the synchronisers have settled
    assign det  = {i_reg_undervolt, i_reg_overcurrent, i_thermal_shutdown, i_thermal_warning,
                   i_system_supply_low, i_input_low, i_input_enabled, i_chip_suspended};
    assign th   = {i_thermal_shutdown, i_thermal_warning, i_system_supply_low,
                   i_input_low & i_input_enabled};
    assign q    = quiet > 3'h4 && i_reg_read;
    assign rd19 = q && i_reg_addr == rfs_pkg::ADDR_OVERCURRENT_LIVE;
    assign rd1a = q && i_reg_addr == rfs_pkg::ADDR_THERMAL_SUPPLY;
    assign rd1b = q && i_reg_addr == rfs_pkg::ADDR_CHIP_SUSPEND;
    assign wr_m = i_reg_write && (i_reg_addr == 8'h1C || i_reg_addr == 8'h1D);
    assign wr_t = i_reg_write && i_reg_addr == rfs_pkg::ADDR_THERMAL_MASK;
    assign rd_x = i_reg_read && (i_reg_addr < 8'h15 || i_reg_addr > 8'h1E);
    always_ff @(posedge i_clock) begin
        det_q <= det;
        quiet <= (i_reset || det != det_q) ? 3'h0 : quiet + {2'h0, quiet != 3'h7};
        act   <= (i_reset || det != det_q || i_reg_write) ? 3'h0 : act + {2'h0, act != 3'h7};
    end
    default clocking @(posedge i_clock); endclocking
    default disable iff (i_reset);
    a_reset_clears: assert property ($fell(i_reset) |-> o_reg_rdata == 8'h00 && !o_interrupt)
        else $error("outputs not clear after reset");
    a_oc_live: assert property (rd19 |=> o_reg_rdata == {1'b0, $past(i_reg_overcurrent)})
        else $error("overcurrent status wrong");
    a_thermal_live: assert property (rd1a |=> o_reg_rdata == $past(th))
        else $error("thermal and supply status wrong");
    a_suspend_live: assert property (rd1b |=> o_reg_rdata[6] == $past(i_chip_suspended))
        else $error("suspend status wrong");
    a_mask_readback: assert property (wr_m ##1 (i_reg_read && $stable(i_reg_addr))
        |=> o_reg_rdata == ($past(i_reg_wdata, 2) & 8'h7F)) else $error("mask readback wrong");
    a_mask3_readback: assert property (wr_t ##1 (i_reg_read && $stable(i_reg_addr))
        |=> o_reg_rdata == $past(i_reg_wdata, 2)) else $error("third mask readback wrong");
    a_unmapped_zero: assert property (rd_x |=> o_reg_rdata == 8'h00)
        else $error("unmapped read not zero");
    a_int_cause: assert property ($rose(o_interrupt) |-> act <= 3'h6)
        else $error("interrupt rose without cause");
endmodule : rfs_fault_status_asserts
bind rfs_fault_status rfs_fault_status_asserts u_chk (
    .i_clock(i_clock), .i_reset(i_reset), .i_reg_addr(i_reg_addr), .i_reg_wdata(i_reg_wdata),
    .i_reg_write(i_reg_write), .i_reg_read(i_reg_read), .o_reg_rdata(o_reg_rdata),
    .i_reg_undervolt(i_reg_undervolt), .i_reg_overcurrent(i_reg_overcurrent),
    .i_thermal_shutdown(i_thermal_shutdown), .i_thermal_warning(i_thermal_warning),
    .i_system_supply_low(i_system_supply_low), .i_input_low(i_input_low),
    .i_input_enabled(i_input_enabled), .i_chip_suspended(i_chip_suspended),
    .o_interrupt(o_interrupt));
`default_nettype wire

// ---- verif/rfs_host_model.sv ----
// register bus host for the fault status block
`timescale 1ns/1ps
`default_nettype none
module rfs_host_model (
    // clock
    input  wire logic       i_clock,
    // register bus
    output var  logic [7:0] o_addr,
    output var  logic [7:0] o_wdata,
    output var  logic       o_write,
    output var  logic       o_read
);
    initial begin
        o_addr  = 8'h00;
        o_wdata = 8'h00;
        o_write = 1'b0;
        o_read  = 1'b0;
    end
    // write with w, read with r, both gives a write then a read of the same place
    task automatic access(input logic [7:0] a, input logic [7:0] d, input logic w, input logic r);
        @(posedge i_clock);
        #1;
        o_addr  = a;
        o_wdata = d;
        o_write = w;
        o_read  = r & ~w;
        @(posedge i_clock);
        #1;
        o_write = 1'b0;
        if (w & r) begin
            o_read = 1'b1;
            @(posedge i_clock);
            #1;
        end
        o_read  = 1'b0;
        // released bus never keeps its last value
        o_addr  = ~a;
        o_wdata = ~d;
    endtask : access
endmodule : rfs_host_model
`default_nettype wire

// ---- verif/tb_top.sv ----
// self-checking bench for the fault status block
`timescale 1ns/1ps
`default_nettype none
module tb_top;
    logic       i_clock, i_reset, wr, rd, ts, tw, sys, susp, irq, pend;
    logic [7:0] addr, wdata, rdata, e17;
    logic [6:0] uv, oc;
    logic [4:0] low, en;
    logic [31:0] v;
    logic [7:0] q[$];
    integer     seed = 32'hEA34;
    int         n_errors = 0;
    int         checked = 0;
    rfs_host_model host (.i_clock(i_clock), .o_addr(addr), .o_wdata(wdata), .o_write(wr),
        .o_read(rd));
    rfs_fault_status DUT (.i_clock(i_clock), .i_reset(i_reset), .i_reg_addr(addr),
        .i_reg_wdata(wdata), .i_reg_write(wr), .i_reg_read(rd), .o_reg_rdata(rdata),
        .i_reg_undervolt(uv), .i_reg_overcurrent(oc), .i_thermal_shutdown(ts),
        .i_thermal_warning(tw), .i_system_supply_low(sys), .i_input_low(low),
        .i_input_enabled(en), .i_chip_suspended(susp), .o_interrupt(irq));
    task automatic complete_run();
        $display("checked %0d n_errors %0d", checked, n_errors);
        if (n_errors == 0 && checked > 0) begin
            $display("STATUS OK");
        end else begin
            $display("STATUS NOT OK");
        end
        $finish;
    endtask : complete_run
    task automatic chk(input logic [7:0] got, input logic [7:0] exp);
        checked++;
        if (got !== exp) begin
            n_errors++;
            $display("[ERR] %0t got %h exp %h", $time, got, exp);
        end
    endtask : chk
    task automatic rdx(input logic [7:0] a, input logic [7:0] e);
        q.push_back(e);
        host.access(a, 8'h00, 1'b0, 1'b1);
    endtask : rdx
    task automatic wrd(input logic [7:0] a, input logic [7:0] d, input logic [7:0] e);
        q.push_back(e);
        host.access(a, d, 1'b1, 1'b1);
    endtask : wrd
    task automatic tick(input int n);
        repeat (n) @(posedge i_clock);
        #1;
    endtask : tick
    // bounded wait on the pin, a timeout ends the run
    task automatic wait_irq(input logic lvl);
        int k;
        for (k = 0; k < 12 && irq !== lvl; k++) tick(1);
        chk({7'h00, irq}, {7'h00, lvl});
        if (irq !== lvl) complete_run();
    endtask : wait_irq
    task automatic zero_all();
        for (int a = 8'h14; a <= 8'h1F; a++) rdx(a[7:0], 8'h00);
    endtask : zero_all
    task automatic do_reset();
        i_reset = 1'b1;
        tick(16);
        i_reset = 1'b0;
    endtask : do_reset
    // read data lands on the read edge, compared half a cycle later
    always @(posedge i_clock) pend <= rd & ~i_reset;
    always @(negedge i_clock) if (pend) chk(rdata, q.pop_front());
    initial begin
        i_clock = 1'b0;
        forever #5 i_clock = ~i_clock;
    end
    initial begin
        {uv, oc, ts, tw, sys, low, en, susp} = '0;
        do_reset();
        zero_all();
        for (int r = 0; r < 4; r++) begin
            v = $random(seed);
            wrd(8'h1C, v[7:0], v[7:0] & rfs_pkg::USED_SEVEN);
            wrd(8'h1D, v[15:8], v[15:8] & rfs_pkg::USED_SEVEN);
            wrd(8'h1E, v[23:16], v[23:16]);
            host.access(8'h19, v[31:24], 1'b1, 1'b0);
            for (int a = 8'h1C; a <= 8'h1E; a++) host.access(a[7:0], 8'hFF, 1'b1, 1'b0);
            v = $random(seed);
            oc = v[6:0] | 7'h01;
            {uv, ts, tw, sys, susp, low, en} = v[27:7];
            e17 = {ts, tw, sys, low & en};
            tick(8);
            chk({7'h00, irq}, 8'h00);
            rdx(8'h19, {1'b0, oc});
            rdx(8'h1A, e17);
            rdx(8'h1B, {1'b0, susp, 6'h00});
            rdx(8'h18, {1'b0, uv});
            host.access(8'h1D, 8'h00, 1'b1, 1'b0);
            wait_irq(1'b1);
            rdx(8'h16, {1'b0, oc});
            wait_irq(1'b0);
            rdx(8'h15, {1'b0, uv});
            rdx(8'h17, e17);
            {uv, oc, ts, tw, sys, low, en, susp} = '0;
            tick(8);
            rdx(8'h17, e17);
            rdx(8'h16, 8'h00);
            rdx(8'h19, 8'h00);
        end
        do_reset();
        zero_all();
        tick(2);
        complete_run();
    end
endmodule : tb_top
`default_nettype wire
